// File: design/sspc_ibuf.sv
// Instruction buffer queue with dual-entry drain
`timescale 1ns/1ps
module sspc_ibuf (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Control
  input  wire logic                flush,
  // Fill side
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire sspc_pkg::sspc_pdi_s in_data,
  // Drain side
  output logic                     out0_valid,
  output sspc_pkg::sspc_pdi_s      out0_data,
  output logic                     out1_valid,
  output sspc_pkg::sspc_pdi_s      out1_data,
  input  wire logic [1:0]          pop_cnt
);
  import sspc_pkg::*;
  sspc_pdi_s          mem [IBUF_DEPTH];
  logic [IBUF_AW-1:0] wr_ptr;
  logic [IBUF_AW-1:0] rd_ptr;
  logic [IBUF_CW-1:0] count;
  logic               push;
  // Status and head entries
  assign in_ready   = (count != IBUF_CW'(IBUF_DEPTH));
  assign push       = in_valid & in_ready & !flush;
  assign out0_valid = (count != IBUF_CW'(0));
  assign out1_valid = (count > IBUF_CW'(1));
  assign out0_data  = mem[rd_ptr];
  assign out1_data  = mem[IBUF_AW'(rd_ptr + IBUF_AW'(1))];
  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= IBUF_AW'(wr_ptr + IBUF_AW'(push));
      rd_ptr <= IBUF_AW'(rd_ptr + IBUF_AW'(pop_cnt));
      count  <= IBUF_CW'(count + IBUF_CW'(push) - IBUF_CW'(pop_cnt));
    end
  end
endmodule // sspc_ibuf

// File: design/sspc_pkg.sv
// Shared constants and types for the dual-issue pipeline control block
package sspc_pkg;
  // ==================================================
  // Sizes
  localparam int NPIPE      = 2;
  localparam int NSTAGE     = 6;
  localparam int IBUF_DEPTH = 8;
  localparam int IBUF_AW    = 3;
  localparam int IBUF_CW    = 4;
  localparam int WBUF_DEPTH = 4;
  localparam int WBUF_AW    = 2;
  localparam int WBUF_CW    = 3;
  localparam int IMM_W      = 24;
  // ==================================================
  // Integer pipeline stage indexes
  localparam int ST_DS = 0;
  localparam int ST_AG = 1;
  localparam int ST_OF = 2;
  localparam int ST_EX = 3;
  localparam int ST_DA = 4;
  localparam int ST_WB = 5;
  // ==================================================
  // Addresses
  localparam logic [31:0] RESET_PC   = 32'h0000_0000;
  localparam logic [31:0] EMU_VECTOR = 32'h0000_0100;
  localparam logic [31:0] INSN_BYTES = 32'h0000_0004;
  // ==================================================
  // Instruction word kind field
  localparam int KIND_MSB = 31;
  localparam int KIND_LSB = 29;
  localparam logic [2:0] K_ALU   = 3'h0;
  localparam logic [2:0] K_LOAD  = 3'h1;
  localparam logic [2:0] K_STORE = 3'h2;
  localparam logic [2:0] K_FP    = 3'h4;
  localparam logic [2:0] K_FPMEM = 3'h5;
  // ==================================================
  // Fixed-length pre-decoded instruction
  typedef struct packed {
    logic [31:0]      pc;
    logic [IMM_W-1:0] imm;
    logic             rd;
    logic             st;
    logic             fp;
    logic             emu;
  } sspc_pdi_s;
  // Write buffer entry
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } sspc_wr_s;
  // Variable word to fixed control format
  function automatic sspc_pdi_s sspc_predecode(input logic [31:0] pc,
                                               input logic [31:0] w);
    sspc_pdi_s r;
    logic [2:0] k;
    k     = w[KIND_MSB:KIND_LSB];
    r.pc  = pc;
    r.imm = w[IMM_W-1:0];
    r.rd  = (k == K_LOAD) || (k == K_FPMEM);
    r.st  = (k == K_STORE);
    r.fp  = (k == K_FP) || (k == K_FPMEM);
    r.emu = !((k == K_ALU) || r.rd || r.st || r.fp);
    return r;
  endfunction
endpackage

// File: design/sspc_top.sv
// Dual-issue pipeline control: fetch, issue, integer pipes, FPU hand-off
`timescale 1ns/1ps
module sspc_top (
  // Clock and reset
  input  wire logic                REF_CLK,
  input  wire logic                RST_B,
  // Mode switches
  input  wire logic                DUAL_DIS,
  input  wire logic                FPU_DIS,
  // Instruction fetch port
  output logic                     FETCH_REQ,
  output logic [31:0]              FETCH_ADDR,
  input  wire logic                FETCH_ACK,
  input  wire logic [31:0]         FETCH_DATA,
  // Branch cache port
  output logic                     BC_LOOKUP,
  output logic [31:0]              BC_ADDR,
  input  wire logic                BC_HIT,
  input  wire logic [31:0]         BC_TARGET,
  // Operand read port
  output logic                     RD_REQ,
  output logic [31:0]              RD_ADDR,
  input  wire logic                RD_ACK,
  input  wire logic [31:0]         RD_DATA,
  // Floating-point unit hand-off
  output logic                     FPU_VALID,
  input  wire logic                FPU_READY,
  output logic [31:0]              FPU_PC,
  output logic [31:0]              FPU_OPND,
  // Bus controller write port
  output logic                     BUS_WR_VALID,
  input  wire logic                BUS_WR_READY,
  output sspc_pkg::sspc_wr_s       BUS_WR,
  // Status
  output logic [1:0]               RETIRE,
  output logic                     EMU_TRAP,
  output logic [31:0]              EMU_PC,
  output logic                     HOLD
);
  import sspc_pkg::*;

  // ==================================================
  // Declarations
  // Fetch pipeline
  logic        ia_v;
  logic [31:0] ia_pc;
  logic        bc_pend;
  logic        if_v;
  logic [31:0] if_pc;
  logic        ed_v;
  logic [31:0] ed_pc;
  logic [31:0] ed_word;
  logic        ib_v;
  sspc_pdi_s   ib_i;
  logic        redirect;
  logic        move_ia;
  logic        move_if;
  logic        move_ed;
  logic        move_ib;
  logic        free_if;
  logic        free_ed;
  logic        free_ib;
  // Instruction buffer
  logic        ibuf_rdy;
  logic        head0_v;
  logic        head1_v;
  sspc_pdi_s   head0;
  sspc_pdi_s   head1;
  logic [1:0]  pop_cnt;
  // Issue
  logic        issue_ok;
  logic        pair_ok;
  logic        issue_v [NPIPE];
  sspc_pdi_s   issue_i [NPIPE];
  // Integer pipes
  logic        st_v [NPIPE][NSTAGE];
  sspc_pdi_s   st_i [NPIPE][NSTAGE];
  logic [31:0] st_d [NPIPE][NSTAGE];
  // Hold and hand-off
  logic        hold;
  logic        rd_need;
  logic        rd_take;
  logic        rd_done;
  logic        fp_need;
  logic        fp_done;
  logic        fp_take;
  logic        wb_need;
  logic        wb_done;
  logic        wb_rdy;
  logic        wb_push;
  logic        trap_cand;
  logic        trap_fire;
  sspc_wr_s    wb_entry;

  // ==================================================
  // Fetch pipeline control
  // hit discards successor
  assign redirect = bc_pend & BC_HIT;
  assign move_ib  = ib_v & ibuf_rdy;
  assign free_ib  = !ib_v | move_ib;
  assign move_ed  = ed_v & free_ib;
  assign free_ed  = !ed_v | move_ed;
  assign move_if  = if_v & FETCH_ACK & free_ed;
  assign free_if  = !if_v | move_if;
  assign move_ia  = ia_v & free_if & !redirect & !trap_fire;

  // Branch cache and fetch requests
  // lookup per fetch address
  assign BC_LOOKUP  = move_ia;
  assign BC_ADDR    = ia_pc;
  assign FETCH_REQ  = if_v;
  assign FETCH_ADDR = if_pc;

  // Stage 1: next instruction address
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ia_v  <= 1'b0;
      ia_pc <= RESET_PC;
    end else begin
      ia_v <= 1'b1;
      if (trap_fire) begin
        ia_pc <= EMU_VECTOR;
      end else if (redirect) begin
        ia_pc <= BC_TARGET;
      end else if (move_ia) begin
        ia_pc <= ia_pc + INSN_BYTES;
      end
    end
  end

  // Pending branch cache answer
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bc_pend <= 1'b0;
    end else begin
      bc_pend <= move_ia;
    end
  end

  // Stage 2: instruction read from memory
  // no stage skipped
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      if_v  <= 1'b0;
      if_pc <= RESET_PC;
    end else if (trap_fire) begin
      if_v <= 1'b0;
    end else if (free_if) begin
      if_v <= move_ia;
      if (move_ia) begin
        if_pc <= ia_pc;
      end
    end
  end

  // Stage 3: raw word held for early decode
  // stage ordering
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ed_v    <= 1'b0;
      ed_pc   <= RESET_PC;
      ed_word <= '0;
    end else if (trap_fire) begin
      ed_v <= 1'b0;
    end else if (free_ed) begin
      ed_v <= move_if;
      if (move_if) begin
        ed_pc   <= if_pc;
        ed_word <= FETCH_DATA;
      end
    end
  end

  // Stage 4: pre-decoded entry toward the buffer
  // fixed format decode
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ib_v <= 1'b0;
      ib_i <= '0;
    end else if (trap_fire) begin
      ib_v <= 1'b0;
    end else if (free_ib) begin
      ib_v <= move_ed;
      if (move_ed) begin
        ib_i <= sspc_predecode(ed_pc, ed_word);
      end
    end
  end

  // ==================================================
  // Instruction buffer
  // decoupling queue
  sspc_ibuf u_ibuf (
    .clk        (REF_CLK),
    .rst_n      (RST_B),
    .flush      (trap_fire),
    .in_valid   (ib_v),
    .in_ready   (ibuf_rdy),
    .in_data    (ib_i),
    .out0_valid (head0_v),
    .out0_data  (head0),
    .out1_valid (head1_v),
    .out1_data  (head1),
    .pop_cnt    (pop_cnt)
  );

  // ==================================================
  // Issue control
  // Second pipe takes only plain register operations
  assign pair_ok  = !head1.rd & !head1.st & !head1.fp & !head1.emu;
  assign issue_ok = !hold & !trap_fire;
  assign issue_v[0] = issue_ok & head0_v;
  assign issue_v[1] = issue_v[0] & head1_v & !DUAL_DIS & pair_ok;
  assign issue_i[0] = head0;
  assign issue_i[1] = head1;
  assign pop_cnt    = 2'(issue_v[0]) + 2'(issue_v[1]);

  // ==================================================
  // Emulation diverts
  // divert to emulation
  assign trap_cand = st_v[0][ST_DS] &
                     (st_i[0][ST_DS].emu | (st_i[0][ST_DS].fp & FPU_DIS));
  assign trap_fire = trap_cand & !hold;

  // Trap report
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      EMU_TRAP <= 1'b0;
      EMU_PC   <= RESET_PC;
    end else begin
      EMU_TRAP <= trap_fire;
      if (trap_fire) begin
        EMU_PC <= st_i[0][ST_DS].pc;
      end
    end
  end

  // ==================================================
  // Integer pipes
  for (genvar p = 0; p < NPIPE; p++) begin : g_pipe
    always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
        st_v[p] <= '{default: 1'b0};
      end else if (!hold) begin
        st_v[p][ST_DS] <= issue_v[p];
        st_v[p][ST_AG] <= st_v[p][ST_DS] & !trap_fire;
        for (int s = ST_OF; s < NSTAGE; s++) begin
          st_v[p][s] <= st_v[p][s-1];
        end
      end
    end

    // Instruction control and data move with the valids
    always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
        st_i[p] <= '{default: '0};
        st_d[p] <= '{default: '0};
      end else if (!hold) begin
        st_i[p][ST_DS] <= issue_i[p];
        for (int s = ST_AG; s < NSTAGE; s++) begin
          st_i[p][s] <= st_i[p][s-1];
        end
        st_d[p][ST_DS] <= '0;
        // Effective address from the displacement
        st_d[p][ST_AG] <= 32'(st_i[p][ST_DS].imm);
        st_d[p][ST_OF] <= st_d[p][ST_AG];
        st_d[p][ST_EX] <= (p == 0 && rd_take) ? RD_DATA : st_d[p][ST_OF];
        // Execute: add displacement to operand
        st_d[p][ST_DA] <= st_d[p][ST_EX] + 32'(st_i[p][ST_EX].imm);
        st_d[p][ST_WB] <= st_d[p][ST_DA];
      end else if (p == 0 && rd_take) begin
        // Operand captured while another hold persists
        st_d[p][ST_OF] <= RD_DATA;
      end
    end
  end

  // ==================================================
  // Operand fetch and FPU hand-off (first pipe only)
  assign rd_need = st_v[0][ST_OF] & st_i[0][ST_OF].rd & !rd_done;
  assign rd_take = rd_need & RD_ACK;
  assign RD_REQ  = rd_need;
  assign RD_ADDR = st_d[0][ST_OF];
  assign fp_need   = st_v[0][ST_OF] & st_i[0][ST_OF].fp & !fp_done;
  assign FPU_VALID = fp_need & (!st_i[0][ST_OF].rd | rd_done);
  assign FPU_PC    = st_i[0][ST_OF].pc;
  assign FPU_OPND  = st_d[0][ST_OF];
  assign fp_take   = FPU_VALID & FPU_READY;

  // ==================================================
  // Write-back and write buffer
  assign wb_need       = st_v[0][ST_WB] & st_i[0][ST_WB].st & !wb_done;
  assign wb_push       = wb_need & wb_rdy;
  assign wb_entry.addr = 32'(st_i[0][ST_WB].imm);
  assign wb_entry.data = st_d[0][ST_WB];

  sspc_wbuf u_wbuf (
    .clk       (REF_CLK),
    .rst_n     (RST_B),
    .in_valid  (wb_need),
    .in_ready  (wb_rdy),
    .in_data   (wb_entry),
    .out_valid (BUS_WR_VALID),
    .out_ready (BUS_WR_READY),
    .out_data  (BUS_WR)
  );

  // ==================================================
  // Pipeline hold
  // keep data until accepted
  assign hold = (rd_need & !RD_ACK) |
                (fp_need & !fp_take) |
                (wb_need & !wb_rdy);
  assign HOLD = hold;

  // Completed side actions, so none repeats under hold
  // no duplicates
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_done <= 1'b0;
      fp_done <= 1'b0;
      wb_done <= 1'b0;
    end else if (hold) begin
      rd_done <= rd_done | rd_take;
      fp_done <= fp_done | fp_take;
      wb_done <= wb_done | wb_push;
    end else begin
      rd_done <= 1'b0;
      fp_done <= 1'b0;
      wb_done <= 1'b0;
    end
  end

  // Retirement pulses per pipe
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RETIRE <= 2'h0;
    end else begin
      RETIRE[0] <= st_v[0][ST_WB] & !hold;
      RETIRE[1] <= st_v[1][ST_WB] & !hold;
    end
  end
endmodule // sspc_top

// File: design/sspc_wbuf.sv
// Four-entry write buffer toward the bus controller
`timescale 1ns/1ps
module sspc_wbuf (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Fill side
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire sspc_pkg::sspc_wr_s in_data,
  // Drain side
  output logic                    out_valid,
  input  wire logic               out_ready,
  output sspc_pkg::sspc_wr_s      out_data
);
  import sspc_pkg::*;
  sspc_wr_s           mem [WBUF_DEPTH];
  logic [WBUF_AW-1:0] wr_ptr;
  logic [WBUF_AW-1:0] rd_ptr;
  logic [WBUF_CW-1:0] count;
  logic               push;
  logic               pop;
  // Status
  assign in_ready  = (count != WBUF_CW'(WBUF_DEPTH));
  assign out_valid = (count != WBUF_CW'(0));
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];
  // Storage, reset so the bus port never shows unknowns
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem <= '{default: '0};
    end else if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= WBUF_AW'(wr_ptr + WBUF_AW'(push));
      rd_ptr <= WBUF_AW'(rd_ptr + WBUF_AW'(pop));
      count  <= WBUF_CW'(count + WBUF_CW'(push) - WBUF_CW'(pop));
    end
  end
endmodule // sspc_wbuf

// File: verification/sspc_mem_model.sv
// Far-side model: instruction memory, branch cache, operand port, FPU, bus
`timescale 1ns/1ps
module sspc_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Behaviour controls
  input  wire logic        slow,
  input  wire logic        fpu_stall,
  input  wire logic        wr_stall,
  // Fetch and branch cache
  input  wire logic [31:0] fetch_addr,
  output logic             fetch_ack,
  output logic [31:0]      fetch_data,
  input  wire logic        bc_lookup,
  input  wire logic [31:0] bc_addr,
  output logic             bc_hit,
  output logic [31:0]      bc_target,
  // Operand, FPU and bus
  input  wire logic [31:0] rd_addr,
  output logic             rd_ack,
  output logic [31:0]      rd_data,
  output logic             fpu_ready,
  output logic             wr_ready
);
  logic [31:0] rom [0:63];
  logic [31:0] br_src = 32'hffff_ffff;
  logic [31:0] br_dst = 32'h0;
  logic        ph;
  logic [31:0] word;
  // Phase for answering every other cycle when slow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ph <= 1'b0;
    else ph <= !ph;
  end
  assign fetch_ack = !slow || ph;
  assign rd_ack    = !slow || !ph;
  assign word      = rom[fetch_addr[7:2]];
  // Data lines carry junk outside an answer
  assign fetch_data = fetch_ack ? word : ~word;
  assign rd_data    = rd_ack ? rd_addr + 32'h1 : ~rd_addr;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) bc_hit <= 1'b0;
    else bc_hit <= bc_lookup && bc_addr == br_src;
  end
  assign bc_target = bc_hit ? br_dst : ~br_dst;
  assign fpu_ready = !fpu_stall;
  assign wr_ready  = !wr_stall;
endmodule // sspc_mem_model

// File: verification/sspc_tb_top.sv
// Self-checking testbench for the pipeline control block
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sspc_tb_top;
  import sspc_pkg::*;
  logic        REF_CLK = 1'b0, RST_B = 1'b0, DUAL_DIS = 1'b0, FPU_DIS = 1'b0;
  logic        slow = 1'b0, fpu_stall = 1'b0, wr_stall = 1'b0;
  logic        FETCH_REQ, FETCH_ACK, BC_LOOKUP, BC_HIT, RD_REQ, RD_ACK, FPU_VALID, FPU_READY;
  logic        BUS_WR_VALID, BUS_WR_READY, EMU_TRAP, HOLD;
  logic [31:0] FETCH_ADDR, FETCH_DATA, BC_ADDR, BC_TARGET, RD_ADDR, RD_DATA, FPU_PC, FPU_OPND, EMU_PC;
  logic [1:0]  RETIRE;
  sspc_wr_s    BUS_WR;
  int          mismatches = 0, cmp_count = 0, ret, r1, pairs, holds;
  logic [31:0] lk[$], trp[$], fq[$], fo[$];
  sspc_wr_s    wq[$];
  always #10 REF_CLK = ~REF_CLK;
  sspc_top uut (.REF_CLK(REF_CLK), .RST_B(RST_B), .DUAL_DIS(DUAL_DIS), .FPU_DIS(FPU_DIS),
    .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR), .FETCH_ACK(FETCH_ACK), .FETCH_DATA(FETCH_DATA),
    .BC_LOOKUP(BC_LOOKUP), .BC_ADDR(BC_ADDR), .BC_HIT(BC_HIT), .BC_TARGET(BC_TARGET),
    .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR), .RD_ACK(RD_ACK), .RD_DATA(RD_DATA),
    .FPU_VALID(FPU_VALID), .FPU_READY(FPU_READY), .FPU_PC(FPU_PC), .FPU_OPND(FPU_OPND),
    .BUS_WR_VALID(BUS_WR_VALID), .BUS_WR_READY(BUS_WR_READY), .BUS_WR(BUS_WR),
    .RETIRE(RETIRE), .EMU_TRAP(EMU_TRAP), .EMU_PC(EMU_PC), .HOLD(HOLD));
  sspc_mem_model mem (.clk(REF_CLK), .rst_n(RST_B), .slow(slow), .fpu_stall(fpu_stall),
    .wr_stall(wr_stall), .fetch_addr(FETCH_ADDR), .fetch_ack(FETCH_ACK), .fetch_data(FETCH_DATA),
    .bc_lookup(BC_LOOKUP), .bc_addr(BC_ADDR), .bc_hit(BC_HIT), .bc_target(BC_TARGET),
    .rd_addr(RD_ADDR), .rd_ack(RD_ACK), .rd_data(RD_DATA), .fpu_ready(FPU_READY),
    .wr_ready(BUS_WR_READY));
  // Port monitor: record lookups, retires, traps and taken transfers
  always @(posedge REF_CLK) if (RST_B) begin
    if (BC_LOOKUP) lk.push_back(BC_ADDR);
    if (EMU_TRAP) trp.push_back(EMU_PC);
    if (FPU_VALID && FPU_READY) begin
      fq.push_back(FPU_PC);
      fo.push_back(FPU_OPND);
    end
    if (BUS_WR_VALID && BUS_WR_READY) wq.push_back(BUS_WR);
    ret = ret + RETIRE[0] + RETIRE[1];
    r1 = r1 + RETIRE[1];
    pairs = pairs + (RETIRE == 2'h3);
    holds = holds + HOLD;
  end
  function automatic logic [31:0] w(input logic [2:0] k, input logic [23:0] d);
    return {k, 5'h0, d};
  endfunction
  // Enter reset, clear program and records
  task automatic restart(input logic dd, input logic fd);
    @(posedge REF_CLK);
    RST_B <= 1'b0;
    DUAL_DIS <= dd;
    FPU_DIS <= fd;
    for (int i = 0; i < 64; i++) mem.rom[i] = 32'h0;
    mem.br_src = 32'hffff_ffff;
    repeat (3) @(posedge REF_CLK);
    lk.delete();
    trp.delete();
    fq.delete();
    fo.delete();
    wq.delete();
    ret = 0;
    r1 = 0;
    pairs = 0;
    holds = 0;
  endtask
  task automatic run(input int n);
    @(posedge REF_CLK);
    RST_B <= 1'b1;
    repeat (n) @(posedge REF_CLK);
  endtask
  // Straight-line code: sequential lookups and steady retire
  task automatic t_seq();
    restart(1'b0, 1'b0);
    run(40);
    for (int i = 0; i < 6; i++) `CHK(lk[i], 4 * i)
    `CHK(ret >= 20, 1'b1)
    $display("test seq done");
  endtask
  // Hit at 0x10 redirects to 0x40
  task automatic t_branch();
    int e[7] = '{'h0, 'h4, 'h8, 'hc, 'h10, 'h40, 'h44};
    restart(1'b0, 1'b0);
    mem.br_src = 32'h10;
    mem.br_dst = 32'h40;
    run(30);
    for (int i = 0; i < 7; i++) `CHK(lk[i], e[i])
    $display("test branch done");
  endtask
  // Unimplemented kinds and disabled FPU divert to the vector
  task automatic t_trap();
    logic [2:0] kd[5] = '{3'h3, 3'h6, 3'h7, K_FP, K_FP};
    for (int f = 0; f < 5; f++) begin
      restart(1'b0, f == 4);
      mem.rom[3] = w(kd[f], 24'h0);
      run(60);
      if (f == 3) begin
        `CHK(trp.size(), 0)
        `CHK(fq[0], 32'hc)
      end else begin
        `CHK(trp[0], 32'hc)
        `CHK(trp[1], 32'h10c)
      end
    end
    $display("test trap done");
  endtask
  // Slow memory and a stalled FPU: one hand-off, integer work resumes after release
  task automatic t_fpu();
    restart(1'b0, 1'b0);
    slow <= 1'b1;
    fpu_stall <= 1'b1;
    mem.rom[2] = w(K_FPMEM, 24'h80);
    mem.rom[4] = w(K_LOAD, 24'h20);
    run(40);
    fpu_stall <= 1'b0;
    repeat (30) @(posedge REF_CLK);
    slow <= 1'b0;
    `CHK(fq.size(), 1)
    `CHK(fq[0], 32'h8)
    `CHK(fo[0], 32'h81)
    `CHK(ret > 10, 1'b1)
    $display("test fpu done");
  endtask
  // Six stores against a stalled bus: fill, hold, drain in order
  task automatic t_store(input logic dd);
    restart(dd, 1'b0);
    wr_stall <= 1'b1;
    for (int i = 0; i < 6; i++) mem.rom[i] = w(K_STORE, 24'(16 * i + 16));
    run(40);
    `CHK(wq.size(), 0)
    `CHK(holds > 0, 1'b1)
    wr_stall <= 1'b0;
    repeat (25) @(posedge REF_CLK);
    `CHK(wq.size(), 6)
    for (int i = 0; i < 6; i++) `CHK(wq[i].addr, 16 * i + 16)
    if (dd) `CHK(r1, 0)
    else `CHK(pairs > 0, 1'b1)
    $display("test store done");
  endtask
  // Print counts and verdict, then end the run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge REF_CLK);
    $display("watchdog expired");
    mismatches++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge REF_CLK);
    `CHK({FETCH_REQ, BC_LOOKUP, RD_REQ, FPU_VALID, BUS_WR_VALID, EMU_TRAP, HOLD, RETIRE}, 9'h0)
    `CHK(FETCH_ADDR, 32'h0)
    t_seq();
    t_branch();
    t_trap();
    t_fpu();
    t_store(1'b0);
    t_store(1'b1);
    stop_test();
  end
endmodule // sspc_tb_top

// File: verification/sspc_top_chk.sv
// Concurrent checks on the pipeline control ports
`timescale 1ns/1ps
module sspc_top_chk (
  // Clock, reset and dual-issue switch
  input wire logic               REF_CLK,
  input wire logic               RST_B,
  input wire logic               DUAL_DIS,
  // Fetch and branch cache
  input wire logic               FETCH_REQ,
  input wire logic [31:0]        FETCH_ADDR,
  input wire logic               FETCH_ACK,
  input wire logic               BC_LOOKUP,
  input wire logic [31:0]        BC_ADDR,
  input wire logic               BC_HIT,
  input wire logic [31:0]        BC_TARGET,
  // Operand, FPU and bus
  input wire logic               RD_REQ,
  input wire logic [31:0]        RD_ADDR,
  input wire logic               RD_ACK,
  input wire logic               FPU_VALID,
  input wire logic               FPU_READY,
  input wire logic [31:0]        FPU_PC,
  input wire logic [31:0]        FPU_OPND,
  input wire logic               BUS_WR_VALID,
  input wire logic               BUS_WR_READY,
  input wire sspc_pkg::sspc_wr_s BUS_WR,
  // Status
  input wire logic [1:0]         RETIRE,
  input wire logic               EMU_TRAP,
  input wire logic               HOLD
);
  import sspc_pkg::*;
  logic        lk_d;
  logic [31:0] exp_addr;
  logic [3:0]  dis_cnt;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // ==================================================
  // Helpers
  // Next lookup address: target after hit, else sequential; the trap cycle is judged apart
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lk_d     <= 1'b0;
      exp_addr <= RESET_PC;
    end else begin
      lk_d <= BC_LOOKUP;
      if (lk_d && BC_HIT) exp_addr <= BC_TARGET;
      else if (BC_LOOKUP) exp_addr <= BC_ADDR + INSN_BYTES;
    end
  end
  // Moving cycles spent with the second pipe switched off
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) dis_cnt <= 4'h0;
    else if (!DUAL_DIS) dis_cnt <= 4'h0;
    else if (dis_cnt != 4'hf && !HOLD) dis_cnt <= dis_cnt + 4'h1;
  end
  sequence s_hit;
    BC_LOOKUP ##1 BC_HIT;
  endsequence
  // ==================================================
  // Assertions
  // lookup address order
  AST_LOOKUP_ADDR: assert property (BC_LOOKUP |-> BC_ADDR == (EMU_TRAP ? EMU_VECTOR : exp_addr))
    else $error("lookup address out of order");
  AST_HIT_GAP: assert property (s_hit |-> !BC_LOOKUP)
    else $error("sequential lookup after a hit");
  AST_FETCH_HOLD: assert property (FETCH_REQ && !FETCH_ACK |=> EMU_TRAP || FETCH_REQ && $stable(FETCH_ADDR))
    else $error("fetch request dropped or changed");
  AST_RD_HOLD: assert property (RD_REQ && !RD_ACK |=> RD_REQ && $stable(RD_ADDR))
    else $error("operand request dropped or changed");
  AST_FPU_HOLD: assert property (FPU_VALID && !FPU_READY |=> FPU_VALID && $stable({FPU_PC, FPU_OPND}))
    else $error("fpu hand-off dropped or changed");
  AST_WR_HOLD: assert property (BUS_WR_VALID && !BUS_WR_READY |=> BUS_WR_VALID && $stable(BUS_WR))
    else $error("bus write dropped or changed");
  AST_DUAL_OFF: assert property (dis_cnt == 4'hf |-> !RETIRE[1])
    else $error("second pipe retired while off");
  AST_HOLD_FREEZE: assert property (HOLD |=> RETIRE == 2'h0)
    else $error("retire during hold");
  AST_TRAP_PULSE: assert property (EMU_TRAP |=> !EMU_TRAP [*3])
    else $error("trap repeated too soon");
endmodule // sspc_top_chk

bind sspc_top sspc_top_chk u_chk (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .DUAL_DIS(DUAL_DIS),
  .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR), .FETCH_ACK(FETCH_ACK),
  .BC_LOOKUP(BC_LOOKUP), .BC_ADDR(BC_ADDR), .BC_HIT(BC_HIT), .BC_TARGET(BC_TARGET),
  .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR), .RD_ACK(RD_ACK),
  .FPU_VALID(FPU_VALID), .FPU_READY(FPU_READY), .FPU_PC(FPU_PC), .FPU_OPND(FPU_OPND),
  .BUS_WR_VALID(BUS_WR_VALID), .BUS_WR_READY(BUS_WR_READY), .BUS_WR(BUS_WR),
  .RETIRE(RETIRE), .EMU_TRAP(EMU_TRAP), .HOLD(HOLD)
);
